// ===== hdl/plc_cluster.sv
// Cluster of eight programmable logic cells with carry, cascade and tri-state emulation.
//
// Summary of operation
// R1 - Each cell has a 4-input lookup table, one register, carry and cascade links.
// R2 - The register acts as a D, T, JK or SR flip-flop.
// R3 - Bypass sends the lookup result straight to the cell outputs.
// R4 - Register clock and clear come from global, pin or internal sources.
// R5 - Local and row outputs are each selected independently.
// R6 - One output may carry the lookup result while the other carries the register.
// R7 - Carry in feeds the cell lookup and the next carry stage upward.
// R8 - Eight cells per cluster; longer chains continue into further clusters.
// R9 - Chains skip alternate clusters; last cell feeds the next cluster's first cell.
// R10 - Chains do not cross the memory block; a new chain starts beyond it.
// R11 - An n-bit adder uses n+1 cells; register is bypassed or accumulates. Here the register only stores the sum, with no feedback.
// R12 - Carry goes straight to the next bit; the final carry lands in a cell.
// R13 - Up/down counters have count enable, clock enable, direction and load.
// R14 - Counters use two 3-input functions and a 2:1 load multiplexer.
// R15 - Counter registers also load asynchronously through clear and preset.
// R16 - Clearable counters take a synchronous clear in place of cascade in.
// R17 - The load multiplexer output is ANDed with the synchronous clear.
// R18 - Emulated tri-state bus reads low on contention, high when undriven.
// R19 - Either cluster control line may serve as the asynchronous clear.
// R20 - In load mode the first control line copies the third input in.
// R21 - Third input held high makes the first control line a preset.
// R22 - Preset may use the clear with register input and output inverted.
// R23 - With load and clear, the second line clears and the first loads.
// R24 - Clock enable low holds the register; asynchronous controls still act.
// R25 - Clear wins over load when both are asserted.
module plc_cluster
  import plc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [7:0]  data_a_i,
  input  wire logic [7:0]  data_b_i,
  input  wire logic [7:0]  cell_input_third_i,
  input  wire logic        carry_in_i,
  input  wire logic        cascade_in_i,
  input  wire logic        cluster_control_first_i,
  input  wire logic        cluster_control_second_i,
  input  wire logic        global_clk_en_i,
  input  wire logic        internal_clk_en_i,
  input  wire logic        pin_clk_i,
  input  wire logic        pin_clear_i,
  input  wire logic        count_enable_i,
  input  wire logic        clock_enable_i,
  input  wire logic        up_down_i,
  input  wire logic        sync_load_i,
  input  wire logic [7:0]  tri_oe_i,
  output logic      [7:0]  local_out_o,
  output logic      [7:0]  row_out_o,
  output logic             carry_out_o,
  output logic             cascade_out_o,
  output logic             tri_bus_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  function automatic logic [31:0] plc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int k = 0; k < 4; k++)
    begin
      if (be[k])
      begin
        res[k*8 +: 8] = new_v[k*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic plc_ff_next(input plc_ff_e kind,
                                       input logic    q,
                                       input logic    d,
                                       input logic    k);
    logic res;
    case (kind)
      PLC_FF_D:  res = d;
      PLC_FF_T:  res = q ^ d;
      PLC_FF_JK: res = (d & ~q) | (~k & q);
      PLC_FF_SR: res = d | (~k & q);
      default:   res = d;
    endcase
    return res;
  endfunction

  function automatic logic plc_tri_resolve(input logic [7:0] drv,
                                           input logic [7:0] oe);
    return (oe == 8'h00) | (((oe & (oe - 8'h01)) == 8'h00) & (|(drv & oe)));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers and bus slave.

  logic [31:0] cfg_reg;
  logic [15:0] lut_reg [PLC_CELLS];
  logic        waitreq_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  q_store_reg;
  logic [7:0]  q_vis;
  logic [7:0]  lut_val;
  logic [7:0]  d_val;
  logic        carry_final;
  logic        casc_final;
  logic        chain;
  logic        casc;
  logic        acc_ok;

  plc_mode_e mode;
  plc_ff_e   ff_kind;
  plc_clk_e  clk_src;
  plc_clr_e  clr_src;

  assign mode    = plc_mode_e'(cfg_reg[PLC_CFG_MODE_LSB +: 2]);
  assign ff_kind = plc_ff_e'(cfg_reg[PLC_CFG_FF_LSB +: 2]);
  assign clk_src = plc_clk_e'(cfg_reg[PLC_CFG_CLK_LSB +: 2]);
  assign clr_src = plc_clr_e'(cfg_reg[PLC_CFG_CLR_LSB +: 2]);
  assign acc_ok  = (avs_read_i | avs_write_i) & ~waitreq_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      waitreq_reg <= 1'b1;
    end
    else
    begin
      waitreq_reg <= ~((avs_read_i | avs_write_i) & waitreq_reg);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      cfg_reg <= PLC_CFG_RESET;
      for (int i = 0; i < PLC_CELLS; i++)
      begin
        lut_reg[i] <= PLC_LUT_RESET;
      end
    end
    else if (avs_write_i && acc_ok)
    begin
      if (avs_address_i == PLC_ADDR_CFG)
      begin
        cfg_reg <= plc_merge(cfg_reg, avs_writedata_i, avs_byteenable_i);
      end
      for (int i = 0; i < PLC_CELLS; i++)
      begin
        if (avs_address_i == PLC_ADDR_LUT0 + 8'(i * 4))
        begin
          lut_reg[i] <= 16'(plc_merge({16'h0000, lut_reg[i]}, avs_writedata_i,
                                      avs_byteenable_i));
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if ((avs_read_i | avs_write_i) && waitreq_reg)
    begin
      rdata_reg <= 32'h0000_0000;
      if (avs_address_i == PLC_ADDR_CFG)
      begin
        rdata_reg <= cfg_reg;
      end
      else if (avs_address_i == PLC_ADDR_STATUS)
      begin
        rdata_reg <= {14'h0000, tri_bus_o, carry_out_o, lut_val, q_vis};
      end
      else if (avs_address_i >= PLC_ADDR_LUT0 && avs_address_i <= PLC_ADDR_LUT7
               && avs_address_i[1:0] == 2'b00)
      begin
        rdata_reg <= {16'h0000, lut_reg[avs_address_i[4:2]]};
      end
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = waitreq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and register control selection.

  logic pclk_s1_reg;
  logic pclk_s2_reg;
  logic pclk_s3_reg;
  logic pclr_s1_reg;
  logic pclr_s2_reg;
  logic clk_fire;
  logic clr_hit;
  logic ld_hit;

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      pclk_s1_reg <= 1'b0;
      pclk_s2_reg <= 1'b0;
      pclk_s3_reg <= 1'b0;
      pclr_s1_reg <= 1'b0;
      pclr_s2_reg <= 1'b0;
    end
    else
    begin
      pclk_s1_reg <= pin_clk_i;
      pclk_s2_reg <= pclk_s1_reg;
      pclk_s3_reg <= pclk_s2_reg;
      pclr_s1_reg <= pin_clear_i;
      pclr_s2_reg <= pclr_s1_reg;
    end
  end

  always_comb
  begin
    case (clk_src) // R4
      PLC_CLK_GLOBAL:   clk_fire = global_clk_en_i;
      PLC_CLK_PIN:      clk_fire = pclk_s2_reg & ~pclk_s3_reg;
      PLC_CLK_INTERNAL: clk_fire = internal_clk_en_i;
      default:          clk_fire = 1'b1;
    endcase
    if (cfg_reg[PLC_CFG_ALOAD])
    begin
      clr_hit = (clr_src != PLC_CLR_FIRST) & cluster_control_second_i; // R23
    end
    else
    begin
      case (clr_src) // R4 R19
        PLC_CLR_FIRST:  clr_hit = cluster_control_first_i;
        PLC_CLR_SECOND: clr_hit = cluster_control_second_i;
        PLC_CLR_PIN:    clr_hit = pclr_s2_reg;
        default:        clr_hit = lut_val[7];
      endcase
    end
    ld_hit = cfg_reg[PLC_CFG_ALOAD] & cluster_control_first_i; // R20 R23
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lookup tables, carry chain and cascade chain.

  assign q_vis = q_store_reg ^ {8{cfg_reg[PLC_CFG_INVERT]}}; // R22

  always_comb
  begin
    chain = cfg_reg[PLC_CFG_CHAIN_START] ? (mode != PLC_MODE_ADDER) : carry_in_i; // R9 R10
    if (mode == PLC_MODE_UPDOWN || mode == PLC_MODE_CLEARABLE)
    begin
      chain = chain & count_enable_i; // R13
    end
    casc    = cascade_in_i;
    lut_val = 8'h00;
    d_val   = 8'h00;
    for (int i = 0; i < PLC_CELLS; i++)
    begin
      case (mode)
        PLC_MODE_ADDER:
        begin
          if (i == PLC_CELLS - 1 && cfg_reg[PLC_CFG_CHAIN_END])
          begin
            lut_val[i] = chain; // R11 R12
          end
          else
          begin
            lut_val[i] = data_a_i[i] ^ data_b_i[i] ^ chain; // R11
            chain = (data_a_i[i] & data_b_i[i]) | (chain & (data_a_i[i] ^ data_b_i[i])); // R12
          end
          d_val[i] = lut_val[i];
        end
        PLC_MODE_UPDOWN:
        begin
          lut_val[i] = q_vis[i] ^ chain; // R14
          chain = (up_down_i ? q_vis[i] : ~q_vis[i]) & chain; // R13 R14
          d_val[i] = sync_load_i ? data_a_i[i] : lut_val[i]; // R14
        end
        PLC_MODE_CLEARABLE:
        begin
          lut_val[i] = q_vis[i] ^ chain;
          chain = q_vis[i] & chain;
          d_val[i] = (sync_load_i ? data_a_i[i] : lut_val[i]) & cascade_in_i; // R16 R17
        end
        default:
        begin
          lut_val[i] = lut_reg[i][{chain, cell_input_third_i[i],
                                   data_b_i[i], data_a_i[i]}]; // R1 R7
          if (cfg_reg[PLC_CFG_CASC_EN])
          begin
            lut_val[i] = lut_val[i] & casc; // R1
          end
          casc = lut_val[i];
          d_val[i] = lut_val[i];
        end
      endcase
    end
    carry_final = chain; // R8
    casc_final  = casc;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cell registers.

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      q_store_reg <= 8'h00;
    end
    else if (clr_hit)
    begin
      q_store_reg <= 8'h00; // R19 R25
    end
    else if (ld_hit)
    begin
      q_store_reg <= cell_input_third_i ^ {8{cfg_reg[PLC_CFG_INVERT]}}; // R15 R20 R21
    end
    else if (clk_fire && clock_enable_i) // R24
    begin
      for (int i = 0; i < PLC_CELLS; i++)
      begin
        q_store_reg[i] <= cfg_reg[PLC_CFG_INVERT] ^ plc_ff_next( // R2
          (mode == PLC_MODE_NORMAL) ? ff_kind : PLC_FF_D, q_vis[i], d_val[i], data_b_i[i]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered cell outputs and tri-state emulation.

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      local_out_o   <= 8'h00;
      row_out_o     <= 8'h00;
      carry_out_o   <= 1'b0;
      cascade_out_o <= 1'b0;
      tri_bus_o     <= 1'b1;
    end
    else
    begin
      local_out_o   <= (cfg_reg[PLC_CFG_LOCAL_REG] & ~cfg_reg[PLC_CFG_BYPASS]) ?
                       q_vis : lut_val; // R3 R5 R6
      row_out_o     <= (cfg_reg[PLC_CFG_ROW_REG] & ~cfg_reg[PLC_CFG_BYPASS]) ?
                       q_vis : lut_val; // R3 R5 R6
      carry_out_o   <= carry_final; // R8 R9
      cascade_out_o <= casc_final;
      tri_bus_o     <= plc_tri_resolve(lut_val, tri_oe_i); // R18
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  clear_wins_a: assert property (clr_hit |=> q_store_reg == 8'h00) // R25
    else $error("Clear did not empty the cell registers.");
  async_load_a: assert property (ld_hit && !clr_hit |=> // R20
    q_vis == $past(cell_input_third_i))
    else $error("Asynchronous load did not copy the third input.");
  hold_value_a: assert property (!clr_hit && !ld_hit && !clock_enable_i |=> // R24
    $stable(q_store_reg))
    else $error("Register changed while clock enable was low.");
  bypass_out_a: assert property (cfg_reg[PLC_CFG_BYPASS] |=> // R3
    local_out_o == $past(lut_val) && row_out_o == $past(lut_val))
    else $error("Bypass did not route the lookup result.");
  tri_float_a: assert property (tri_oe_i == 8'h00 |=> tri_bus_o) // R18
    else $error("Undriven bus did not read high.");
  tri_contend_a: assert property ($countones(tri_oe_i) > 1 |=> !tri_bus_o) // R18
    else $error("Contending bus did not read low.");
  sync_clear_a: assert property (mode == PLC_MODE_CLEARABLE && !cascade_in_i && // R17
    clk_fire && clock_enable_i && !clr_hit && !ld_hit |=> q_vis == 8'h00)
    else $error("Synchronous clear did not zero the counter.");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("Bus answer was not a single cycle.");

  count_tick_c: cover property (mode == PLC_MODE_UPDOWN && clk_fire && clock_enable_i);
  clear_load_c: cover property (clr_hit && ld_hit);
  tri_contend_c: cover property ($countones(tri_oe_i) > 1);
  bus_write_c: cover property (avs_write_i && !avs_waitrequest_o);

endmodule

// ===== shared/plc_pkg.sv
// Constants, field layouts and enumerations for the programmable logic cell cluster.
package plc_pkg;

  localparam int          PLC_CELLS        = 8;
  localparam logic [7:0]  PLC_ADDR_CFG     = 8'h00;
  localparam logic [7:0]  PLC_ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  PLC_ADDR_LUT0    = 8'h20;
  localparam logic [7:0]  PLC_ADDR_LUT7    = 8'h3C;
  localparam logic [31:0] PLC_CFG_RESET    = 32'h0000_0000;
  localparam logic [15:0] PLC_LUT_RESET    = 16'h0000;

  localparam int PLC_CFG_MODE_LSB    = 0;
  localparam int PLC_CFG_FF_LSB      = 2;
  localparam int PLC_CFG_BYPASS      = 4;
  localparam int PLC_CFG_CLK_LSB     = 5;
  localparam int PLC_CFG_CLR_LSB     = 7;
  localparam int PLC_CFG_ALOAD       = 9;
  localparam int PLC_CFG_INVERT      = 10;
  localparam int PLC_CFG_LOCAL_REG   = 11;
  localparam int PLC_CFG_ROW_REG     = 12;
  localparam int PLC_CFG_CASC_EN     = 13;
  localparam int PLC_CFG_CHAIN_START = 14;
  localparam int PLC_CFG_CHAIN_END   = 15;
  localparam int PLC_ST_CARRY        = 16;
  localparam int PLC_ST_TRIBUS       = 17;

  typedef enum logic [1:0] {
    PLC_MODE_NORMAL    = 2'b00,
    PLC_MODE_ADDER     = 2'b01,
    PLC_MODE_UPDOWN    = 2'b10,
    PLC_MODE_CLEARABLE = 2'b11
  } plc_mode_e;

  typedef enum logic [1:0] {
    PLC_FF_D  = 2'b00,
    PLC_FF_T  = 2'b01,
    PLC_FF_JK = 2'b10,
    PLC_FF_SR = 2'b11
  } plc_ff_e;

  typedef enum logic [1:0] {
    PLC_CLK_GLOBAL   = 2'b00,
    PLC_CLK_PIN      = 2'b01,
    PLC_CLK_INTERNAL = 2'b10,
    PLC_CLK_FREE     = 2'b11
  } plc_clk_e;

  typedef enum logic [1:0] {
    PLC_CLR_FIRST    = 2'b00,
    PLC_CLR_SECOND   = 2'b01,
    PLC_CLR_PIN      = 2'b10,
    PLC_CLR_INTERNAL = 2'b11
  } plc_clr_e;

endpackage

// ===== test/plc_neighbour_model.sv
// Lower-order neighbouring cell that feeds the cluster carry and cascade inputs.
module plc_neighbour_model
(
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic op_a_i,
  input  wire logic op_b_i,
  input  wire logic casc_i,
  output logic      carry_o,
  output logic      cascade_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Carry is generated on the same clock, as a neighbour cell would.
  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      carry_o   <= 1'b0;
      cascade_o <= 1'b1;
    end
    else
    begin
      carry_o   <= op_a_i & op_b_i;
      cascade_o <= casc_i;
    end
  end
endmodule

// ===== test/test_programmable_logic_cell.sv
// Self-checking bench for the logic cell cluster.
module test_programmable_logic_cell
  import plc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] f_byp = 32'h0000_0010;
  localparam logic [31:0] f_al  = 32'h0000_0200;
  localparam logic [31:0] f_inv = 32'h0000_0400;
  localparam logic [31:0] f_lr  = 32'h0000_0800;
  localparam logic [31:0] f_cs  = 32'h0000_4000;
  localparam logic [31:0] f_cas = 32'h0000_2000;
  localparam logic [31:0] f_end = 32'h0000_8000;
  typedef struct packed {logic [7:0] a; logic [7:0] b; logic [7:0] oe; logic [7:0] lo;
                         logic t;} plc_tb_row_s;
  localparam plc_tb_row_s rows [5] = '{'{8'hFF, 8'h0F, 8'h00, 8'h0F, 1'b1},
    '{8'hFF, 8'h0F, 8'h01, 8'h0F, 1'b1}, '{8'hFF, 8'h0F, 8'h80, 8'h0F, 1'b0},
    '{8'hF0, 8'hFF, 8'h18, 8'hF0, 1'b0}, '{8'h00, 8'h00, 8'hFF, 8'h00, 1'b0}};
  localparam logic [7:0] ff_exp [4] = '{8'h3C, 8'h33, 8'h3F, 8'h3F};
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wd      = 32'h0000_0000;
  logic [3:0]  be      = 4'hF;
  logic [7:0]  a       = 8'h00;
  logic [7:0]  b       = 8'h00;
  logic [7:0]  th      = 8'h00;
  logic [7:0]  oe      = 8'h00;
  logic        ctl1    = 1'b0;
  logic        ctl2    = 1'b0;
  logic        gce     = 1'b0;
  logic        ice     = 1'b0;
  logic        pclk    = 1'b0;
  logic        pclr    = 1'b0;
  logic        cen     = 1'b0;
  logic        ce      = 1'b0;
  logic        ud      = 1'b0;
  logic        sl      = 1'b0;
  logic        nb_a    = 1'b0;
  logic        nb_b    = 1'b0;
  logic        nb_c    = 1'b1;
  logic        cin;
  logic        casc;
  logic [31:0] rdat;
  logic        wrq;
  logic [7:0]  lo;
  logic [7:0]  ro;
  logic        co;
  logic        cso;
  logic        tbus;
  logic [31:0] q;
  int          error_cnt   = 0;
  int          comparisons = 0;

  always #10 sys_clk = ~sys_clk;

  plc_cluster DUT (.sys_clk_i(sys_clk), .resetn_i(rstn), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .data_a_i(a), .data_b_i(b),
    .cell_input_third_i(th), .carry_in_i(cin), .cascade_in_i(casc),
    .cluster_control_first_i(ctl1), .cluster_control_second_i(ctl2),
    .global_clk_en_i(gce), .internal_clk_en_i(ice), .pin_clk_i(pclk), .pin_clear_i(pclr),
    .count_enable_i(cen), .clock_enable_i(ce), .up_down_i(ud), .sync_load_i(sl),
    .tri_oe_i(oe), .local_out_o(lo), .row_out_o(ro), .carry_out_o(co),
    .cascade_out_o(cso), .tri_bus_o(tbus));

  plc_neighbour_model NB (.sys_clk_i(sys_clk), .resetn_i(rstn), .op_a_i(nb_a),
    .op_b_i(nb_b), .casc_i(nb_c), .carry_o(cin), .cascade_o(casc));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One bus cycle; the request is held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    adr <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wrq !== 1'b0 && n < 100);
    q = rdat;
    if (n >= 100)
    begin
      error_cnt++;
      $display("mismatch waitrequest expected 0 seen %b", wrq);
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic cfg(input logic [1:0] m, input logic [1:0] f, input logic [1:0] c,
                     input logic [1:0] r, input logic [31:0] fl);
    logic [31:0] v;
    v = fl;
    v[PLC_CFG_MODE_LSB +: 2] = m;
    v[PLC_CFG_FF_LSB +: 2] = f;
    v[PLC_CFG_CLK_LSB +: 2] = c;
    v[PLC_CFG_CLR_LSB +: 2] = r;
    bus(1'b1, PLC_ADDR_CFG, v);
  endtask

  task automatic luts(input logic [15:0] v);
    for (int i = 0; i < PLC_CELLS; i++)
      bus(1'b1, PLC_ADDR_LUT0 + 8'(4 * i), {16'h0000, v});
  endtask

  task automatic tick(input int n);
    @(posedge sys_clk);
    ce <= 1'b1;
    repeat (n) @(posedge sys_clk);
    ce <= 1'b0;
    cyc(3);
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: gce <= 1'b1;
      1: pclk <= 1'b1;
      2: ice <= 1'b1;
      3: ctl1 <= 1'b1;
      4: ctl2 <= 1'b1;
      default: pclr <= 1'b1;
    endcase
    @(posedge sys_clk);
    {gce, pclk, ice, ctl1, ctl2, pclr} <= 6'h00;
    cyc(5);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    error_cnt++;
    $display("mismatch watchdog expected finish seen timeout");
    complete_run();
  end

  initial
  begin
    cyc(10);
    chk("reset wait", 8'h01, {7'h00, wrq});
    chk("reset bus", 8'h01, {7'h00, tbus});
    chk("reset out", 8'h00, lo);
    rstn <= 1'b1;
    cfg(PLC_MODE_NORMAL, PLC_FF_D, PLC_CLK_GLOBAL, PLC_CLR_SECOND, f_byp);
    bus(1'b0, PLC_ADDR_CFG, 32'h0000_0000);
    chk("cfg lo", 8'h90, q[7:0]);
    chk("cfg hi", 8'h00, q[15:8]);
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", 8'h00, q[7:0]);
    be <= 4'h2;
    bus(1'b1, PLC_ADDR_CFG, 32'hFFFF_FFFF);
    be <= 4'hF;
    bus(1'b0, PLC_ADDR_CFG, 32'h0000_0000);
    chk("be lo", 8'h90, q[7:0]);
    chk("be hi", 8'hFF, q[15:8]);
    chk("be top", 8'h00, q[23:16]);
    cfg(PLC_MODE_NORMAL, PLC_FF_D, PLC_CLK_GLOBAL, PLC_CLR_SECOND, f_byp);
    luts(16'h8888);
    foreach (rows[i])
    begin
      a <= rows[i].a;
      b <= rows[i].b;
      oe <= rows[i].oe;
      cyc(3);
      chk("local", rows[i].lo, lo);
      chk("row", rows[i].lo, ro);
      chk("tribus", {7'h00, rows[i].t}, {7'h00, tbus});
    end
    cfg(PLC_MODE_NORMAL, PLC_FF_D, PLC_CLK_GLOBAL, PLC_CLR_SECOND, f_byp | f_cas);
    a <= 8'hFF;
    b <= 8'hFE;
    cyc(3);
    chk("cascade lo", 8'h00, lo);
    chk("cascade out", 8'h00, {7'h00, cso});
    b <= 8'hFF;
    cyc(3);
    chk("cascade lo", 8'hFF, lo);
    chk("cascade out", 8'h01, {7'h00, cso});
    cfg(PLC_MODE_ADDER, PLC_FF_D, PLC_CLK_GLOBAL, PLC_CLR_SECOND, f_byp | f_cs);
    luts(16'h9966);
    a <= 8'h3C;
    b <= 8'h0F;
    cyc(3);
    chk("sum", 8'h4B, lo);
    a <= 8'hFF;
    b <= 8'h01;
    cyc(3);
    chk("sum wrap", 8'h00, lo);
    chk("carry", 8'h01, {7'h00, co});
    oe <= 8'h00;
    bus(1'b0, PLC_ADDR_STATUS, 32'h0000_0000);
    chk("status flags", 8'h03, q[23:16]);
    chk("status lut", 8'h00, q[15:8]);
    cfg(PLC_MODE_ADDER, PLC_FF_D, PLC_CLK_GLOBAL, PLC_CLR_SECOND, f_byp | f_cs | f_end);
    a <= 8'hC0;
    b <= 8'h40;
    cyc(3);
    chk("sum end", 8'h80, lo);
    chk("carry end", 8'h01, {7'h00, co});
    cfg(PLC_MODE_ADDER, PLC_FF_D, PLC_CLK_GLOBAL, PLC_CLR_SECOND, f_byp);
    nb_a <= 1'b1;
    nb_b <= 1'b1;
    a <= 8'h01;
    b <= 8'h02;
    cyc(3);
    chk("sum cin", 8'h04, lo);
    luts(16'hAAAA);
    ce <= 1'b1;
    for (int f = 0; f < 4; f++)
    begin
      cfg(PLC_MODE_NORMAL, 2'(f), PLC_CLK_GLOBAL, PLC_CLR_SECOND, f_lr);
      pulse(4);
      a <= 8'h0F;
      b <= 8'hC0;
      pulse(0);
      chk("ff first", 8'h0F, lo);
      a <= 8'h3C;
      pulse(0);
      chk("ff second", ff_exp[f], lo);
      chk("row lut", 8'h3C, ro);
    end
    for (int k = 1; k < 3; k++)
    begin
      cfg(PLC_MODE_NORMAL, PLC_FF_D, 2'(k), PLC_CLR_SECOND, f_lr);
      a <= 8'(8'h21 << k);
      pulse(k);
      chk("clk src", 8'(8'h21 << k), lo);
    end
    ce <= 1'b0;
    a <= 8'hFF;
    pulse(2);
    chk("hold", 8'h84, lo);
    for (int k = 0; k < 3; k++)
    begin
      cfg(PLC_MODE_NORMAL, PLC_FF_D, PLC_CLK_GLOBAL, 2'(k), f_lr);
      ce <= 1'b1;
      pulse(0);
      pulse(k + 3);
      chk("clear src", 8'h00, lo);
    end
    a <= 8'h7F;
    cfg(PLC_MODE_NORMAL, PLC_FF_D, PLC_CLK_GLOBAL, PLC_CLR_INTERNAL, f_lr);
    pulse(0);
    chk("int keep", 8'h7F, lo);
    a <= 8'h80;
    cyc(3);
    chk("int clear", 8'h00, lo);
    cfg(PLC_MODE_NORMAL, PLC_FF_D, PLC_CLK_GLOBAL, PLC_CLR_SECOND, f_lr | f_al);
    ce <= 1'b0;
    a <= 8'h5A;
    th <= 8'hC3;
    pulse(3);
    chk("aload", 8'hC3, lo);
    chk("aload row", 8'h5A, ro);
    th <= 8'hFF;
    pulse(3);
    chk("preset", 8'hFF, lo);
    @(posedge sys_clk);
    ctl1 <= 1'b1;
    ctl2 <= 1'b1;
    @(posedge sys_clk);
    ctl1 <= 1'b0;
    ctl2 <= 1'b0;
    cyc(5);
    chk("clear wins", 8'h00, lo);
    cfg(PLC_MODE_NORMAL, PLC_FF_D, PLC_CLK_GLOBAL, PLC_CLR_SECOND, f_lr | f_inv);
    ce <= 1'b1;
    a <= 8'h0F;
    pulse(0);
    chk("inv load", 8'h0F, lo);
    ce <= 1'b0;
    pulse(4);
    chk("inv preset", 8'hFF, lo);
    cfg(PLC_MODE_UPDOWN, PLC_FF_D, PLC_CLK_FREE, PLC_CLR_SECOND, f_lr | f_cs);
    cen <= 1'b1;
    sl <= 1'b1;
    a <= 8'h10;
    tick(1);
    chk("cnt load", 8'h10, lo);
    sl <= 1'b0;
    ud <= 1'b1;
    tick(3);
    chk("cnt up", 8'h13, lo);
    ud <= 1'b0;
    tick(5);
    chk("cnt down", 8'h0E, lo);
    cen <= 1'b0;
    tick(2);
    chk("cnt off", 8'h0E, lo);
    cfg(PLC_MODE_CLEARABLE, PLC_FF_D, PLC_CLK_FREE, PLC_CLR_SECOND, f_lr | f_cs);
    cen <= 1'b1;
    tick(2);
    chk("clr cnt", 8'h10, lo);
    nb_c <= 1'b0;
    sl <= 1'b1;
    cyc(2);
    tick(1);
    chk("sync clear", 8'h00, lo);
    complete_run();
  end
endmodule
